/* File: reg_host_model.sv */
/*
 Host model reaching the configuration registers.
 Assumes strobes are taken on the rising clock edge.
*/
`timescale 1ns/10ps
module reg_host_model (
  input wire clock_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o,
  output reg wr_o,
  output reg [7:0] wdata_o,
  output reg rd_o
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = 18'h0_0000;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock_i);
      #2;
      {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
      @(posedge clock_i);
      #2;
      {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clock_i);
      #2;
      {addr_o, rd_o} = {a, 1'b1};
      @(posedge clock_i);
      #2;
      {addr_o, rd_o} = {~a, 1'b0};
      d = rdata_i;
    end
  endtask
endmodule

/* File: tap_ms_timer.v */
/*
 Millisecond duration timer used for the tap quiet, shock and window times.
 Assumes a one-cycle millisecond tick from the instantiating module.
*/
`timescale 1ns/10ps
module tap_ms_timer #(
  parameter W = 10
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire tick_i,
  input wire start_i,
  input wire [W-1:0] dur_ms_i,
  output reg busy_o,
  output reg done_o
);
  reg [W-1:0] cnt_r;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= {W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // Restart drops any running interval
        cnt_r <= dur_ms_i;
        busy_o <= 1'b1;
      end else if (busy_o && tick_i) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          cnt_r <= {W{1'b0}};
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: tap_orient_defines.vh */
/*
 Constants for the tap and orientation configuration block.
 Assumes inclusion by bare name from design files in the same folder.
*/
`ifndef TAP_ORIENT_DEFINES_VH
`define TAP_ORIENT_DEFINES_VH

`define CLK_HZ 40000000
`define MS_PER_S 1000

`define ADDR_TAP_TIMING 8'h63
`define ADDR_TAP_THRESH 8'h64
`define ADDR_ORIENT_MODE 8'h65
`define ADDR_ORIENT_AXIS 8'h66

`define RST_TAP_TIMING 8'h04
`define RST_TAP_THRESH 8'h0A
`define RST_ORIENT_MODE 8'h18
`define RST_ORIENT_AXIS 8'h48

`define TAP_QUIET_BIT 7
`define TAP_SHOCK_BIT 6
`define TAP_DUR_HI 2
`define TAP_TH_HI 4
`define OR_HYST_HI 7
`define OR_HYST_LO 4
`define OR_BLK_HI 3
`define OR_BLK_LO 2
`define OR_MODE_HI 1
`define AXES_BIT 7
`define UD_EN_BIT 6
`define THETA_HI 5

`define QUIET_MS_0 10'd30
`define QUIET_MS_1 10'd20
`define SHOCK_MS_0 10'd50
`define SHOCK_MS_1 10'd75
`define WIN_MS_0 10'd50
`define WIN_MS_1 10'd100
`define WIN_MS_2 10'd150
`define WIN_MS_3 10'd200
`define WIN_MS_4 10'd250
`define WIN_MS_5 10'd375
`define WIN_MS_6 10'd500
`define WIN_MS_7 10'd700
`define STABLE_MS 7'd100

`define BLK_NONE 2'b00
`define BLK_THETA_G 2'b01
`define BLK_SLOPE_02 2'b10
`define BLK_SLOPE_04 2'b11

`define MODE_SYM 2'b00
`define MODE_HIGH_ASYM 2'b01
`define MODE_LOW_ASYM 2'b10

`endif

/* File: tap_orient_int_config.v */
/*
 Tap and orientation interrupt configuration registers and the behaviour
 they select: tap durations, range-scaled tap threshold, orientation
 hysteresis, blocking, switching mode, axis remap and up/down enable.
 Assumes a register port from the serial interface synchronous to
 clock_i, and detector inputs from the sensor data path.
*/
// Functional notes
// [R1] Tap quiet time is 30 ms with the select bit clear and 20 ms when set.
// [R2] Tap shock time is 50 ms with the select bit clear and 75 ms when set.
// [R3] Window codes 0..7 give 50,100,150,200,250,375,500,700 ms.
// [R4] Pre-filtered tap data source keeps the sensor out of low-power mode.
// [R5] Tap threshold is the field times 62.5,125,250,500 mg by range.
// [R6] A zero threshold field counts as one half in the scaling.
// [R7] Each hysteresis step is 62.5 mg whatever the range.
// [R8] Blocking 0 is off, 1 blocks on theta or >1.5g, 2 adds slope >0.2 g.
// [R9] Blocking 3 uses theta, slope >0.4 g, >1.5g or orientation unstable.
// [R10] Mode 0 and 3 are symmetrical, 1 high-asymmetrical, 2 low-asymmetric.
// [R11] Axis rotation maps x from sensor y, y from z, z from x when set.
// [R12] An up/down change raises an orientation interrupt only when enabled.
// [R13] The six-bit angle field sets the theta blocking angle up to 44.8 deg.
// [R14] Tap threshold range comes from an outside setting at each compare.
`timescale 1ns/10ps
`include "tap_orient_defines.vh"
module tap_orient_int_config #(
  parameter MS_CYCLES = `CLK_HZ / `MS_PER_S,
  parameter AW = 16
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire tap_prefilt_sel_i,
  output reg lowpower_inhibit_o,
  input wire [1:0] acc_range_i,
  input wire [AW-1:0] tap_diff_i,
  input wire tap_diff_valid_i,
  output reg tap_over_thresh_o,
  output reg [8:0] tap_threshold_o,
  input wire tap_quiet_start_i,
  input wire tap_shock_start_i,
  input wire tap_window_start_i,
  output wire tap_quiet_busy_o,
  output wire tap_shock_busy_o,
  output wire tap_window_busy_o,
  output wire tap_quiet_done_o,
  output wire tap_shock_done_o,
  output wire tap_window_done_o,
  input wire [AW-1:0] sens_x_i,
  input wire [AW-1:0] sens_y_i,
  input wire [AW-1:0] sens_z_i,
  output reg [AW-1:0] orient_x_o,
  output reg [AW-1:0] orient_y_o,
  output reg [AW-1:0] orient_z_o,
  output reg [4:0] orient_hyst_o,
  output reg [1:0] orient_thresh_mode_o,
  output reg [5:0] orient_theta_o,
  input wire [5:0] tilt_angle_i,
  input wire over_1g5_i,
  input wire slope_over_0g2_i,
  input wire slope_over_0g4_i,
  input wire [2:0] orient_value_i,
  input wire orient_other_change_i,
  input wire orient_ud_change_i,
  output reg orient_blocked_o,
  output reg orient_irq_o
);
  reg [7:0] tap_timing_config_r;
  reg [7:0] tap_threshold_config_r;
  reg [7:0] orientation_mode_config_r;
  reg [7:0] orientation_axis_angle_config_r;
  reg [15:0] ms_cnt_r;
  reg ms_tick_r;
  reg [2:0] orient_prev_r;
  reg [6:0] stable_ms_r;
  reg [9:0] quiet_ms;
  reg [9:0] shock_ms;
  reg [9:0] window_ms;
  reg [8:0] thr_nxt;
  reg blocked_nxt;
  reg [1:0] mode_nxt;
  wire [4:0] tap_threshold;
  wire [1:0] blk_mode;
  wire axis_rotation_sel;
  wire updown_change_irq_enable;
  wire theta_block;
  wire orient_stable;
  wire [29:0] dur_bus;
  wire [2:0] start_bus;
  wire [2:0] busy_bus;
  wire [2:0] done_bus;

  assign tap_threshold = tap_threshold_config_r[`TAP_TH_HI:0];
  assign blk_mode = orientation_mode_config_r[`OR_BLK_HI:`OR_BLK_LO];
  assign axis_rotation_sel = orientation_axis_angle_config_r[`AXES_BIT];
  assign updown_change_irq_enable =
    orientation_axis_angle_config_r[`UD_EN_BIT];

  // Register stores, reserved bits held at zero
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_timing_config_r <= `RST_TAP_TIMING;
      tap_threshold_config_r <= `RST_TAP_THRESH;
      orientation_mode_config_r <= `RST_ORIENT_MODE;
      orientation_axis_angle_config_r <= `RST_ORIENT_AXIS;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `ADDR_TAP_TIMING: tap_timing_config_r <= reg_wdata_i & 8'hC7;
          `ADDR_TAP_THRESH: tap_threshold_config_r <= reg_wdata_i & 8'h1F;
          `ADDR_ORIENT_MODE: orientation_mode_config_r <= reg_wdata_i;
          `ADDR_ORIENT_AXIS: orientation_axis_angle_config_r <= reg_wdata_i;
          default: ;
        endcase
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ADDR_TAP_TIMING: reg_rdata_o <= tap_timing_config_r;
          `ADDR_TAP_THRESH: reg_rdata_o <= tap_threshold_config_r;
          `ADDR_ORIENT_MODE: reg_rdata_o <= orientation_mode_config_r;
          `ADDR_ORIENT_AXIS: reg_rdata_o <= orientation_axis_angle_config_r;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Duration selection in milliseconds
  always @* begin
    // [R1] Quiet time select
    quiet_ms = tap_timing_config_r[`TAP_QUIET_BIT] ? `QUIET_MS_1 : `QUIET_MS_0;
    // [R2] Shock time select
    shock_ms = tap_timing_config_r[`TAP_SHOCK_BIT] ? `SHOCK_MS_1 : `SHOCK_MS_0;
    // [R3] Second tap window
    case (tap_timing_config_r[`TAP_DUR_HI:0])
      3'h0: window_ms = `WIN_MS_0;
      3'h1: window_ms = `WIN_MS_1;
      3'h2: window_ms = `WIN_MS_2;
      3'h3: window_ms = `WIN_MS_3;
      3'h4: window_ms = `WIN_MS_4;
      3'h5: window_ms = `WIN_MS_5;
      3'h6: window_ms = `WIN_MS_6;
      default: window_ms = `WIN_MS_7;
    endcase
  end

  // Millisecond tick shared by all timers
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == MS_CYCLES[15:0] - 16'h0001) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  assign dur_bus = {window_ms, shock_ms, quiet_ms};
  assign start_bus = {tap_window_start_i, tap_shock_start_i,
    tap_quiet_start_i};
  assign tap_quiet_busy_o = busy_bus[0];
  assign tap_shock_busy_o = busy_bus[1];
  assign tap_window_busy_o = busy_bus[2];
  assign tap_quiet_done_o = done_bus[0];
  assign tap_shock_done_o = done_bus[1];
  assign tap_window_done_o = done_bus[2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
      tap_ms_timer #(
        .W(10)
      ) u_tmr (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(ms_tick_r),
        .start_i(start_bus[gi]),
        .dur_ms_i(dur_bus[gi*10 +: 10]),
        .busy_o(busy_bus[gi]),
        .done_o(done_bus[gi])
      );
    end
  endgenerate

  // Threshold in 31.25 mg units, scaled by range
  always @* begin
    // [R6] Zero field counts as half
    if (tap_threshold == 5'h00)
      thr_nxt = 9'h001;
    else
      thr_nxt = {3'b000, tap_threshold, 1'b0};
    // [R5] Range scaling of threshold
    thr_nxt = thr_nxt << acc_range_i;
  end

  // Orientation stability time since last value change
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      orient_prev_r <= 3'h0;
      stable_ms_r <= 7'h00;
    end else begin
      orient_prev_r <= orient_value_i;
      if (orient_value_i != orient_prev_r)
        stable_ms_r <= 7'h00;
      else if (ms_tick_r && stable_ms_r < `STABLE_MS)
        stable_ms_r <= stable_ms_r + 7'h01;
    end
  end
  assign orient_stable = (stable_ms_r >= `STABLE_MS);

  // [R13] Theta beyond blocking angle
  assign theta_block = tilt_angle_i >
    orientation_axis_angle_config_r[`THETA_HI:0];

  always @* begin
    case (blk_mode)
      // [R8] Blocking modes 0 to 2
      `BLK_NONE: blocked_nxt = 1'b0;
      `BLK_THETA_G: blocked_nxt = theta_block | over_1g5_i;
      `BLK_SLOPE_02: blocked_nxt = theta_block | over_1g5_i |
        slope_over_0g2_i;
      // [R9] Full blocking with stability
      `BLK_SLOPE_04: blocked_nxt = theta_block | over_1g5_i |
        slope_over_0g4_i | ~orient_stable;
      default: blocked_nxt = 1'b0;
    endcase
    // [R10] Switching threshold mode
    case (orientation_mode_config_r[`OR_MODE_HI:0])
      `MODE_HIGH_ASYM: mode_nxt = `MODE_HIGH_ASYM;
      `MODE_LOW_ASYM: mode_nxt = `MODE_LOW_ASYM;
      default: mode_nxt = `MODE_SYM;
    endcase
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lowpower_inhibit_o <= 1'b0;
      tap_threshold_o <= 9'h000;
      tap_over_thresh_o <= 1'b0;
      orient_x_o <= {AW{1'b0}};
      orient_y_o <= {AW{1'b0}};
      orient_z_o <= {AW{1'b0}};
      orient_hyst_o <= 5'h00;
      orient_thresh_mode_o <= `MODE_SYM;
      orient_theta_o <= 6'h00;
      orient_blocked_o <= 1'b0;
      orient_irq_o <= 1'b0;
    end else begin
      // [R4] Hold off low-power mode
      lowpower_inhibit_o <= tap_prefilt_sel_i;
      tap_threshold_o <= thr_nxt;
      // [R14] Range sampled per compare
      if (tap_diff_valid_i)
        tap_over_thresh_o <= (tap_diff_i >= {{(AW-9){1'b0}}, thr_nxt});
      else
        tap_over_thresh_o <= 1'b0;
      // [R11] Axis rotation remap
      if (axis_rotation_sel) begin
        orient_x_o <= sens_y_i;
        orient_y_o <= sens_z_i;
        orient_z_o <= sens_x_i;
      end else begin
        orient_x_o <= sens_x_i;
        orient_y_o <= sens_y_i;
        orient_z_o <= sens_z_i;
      end
      // [R7] Hysteresis in 31.25 mg units
      orient_hyst_o <= {orientation_mode_config_r[`OR_HYST_HI:`OR_HYST_LO],
        1'b0};
      orient_thresh_mode_o <= mode_nxt;
      orient_theta_o <= orientation_axis_angle_config_r[`THETA_HI:0];
      orient_blocked_o <= blocked_nxt;
      // [R12] Up/down change gating
      orient_irq_o <= ~blocked_nxt & (orient_other_change_i |
        (orient_ud_change_i & updown_change_irq_enable));
    end
  end
endmodule

/* File: tap_orient_int_config_assertions.sv */
/*
 Checker of the tap and orientation configuration block.
 Sees only the block's ports; mirrors the two orientation registers.
*/
`timescale 1ns/10ps
`include "tap_orient_defines.vh"
module tap_orient_checker #(
  parameter AW = 16
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire tap_prefilt_sel_i,
  input wire lowpower_inhibit_o,
  input wire [AW-1:0] tap_diff_i,
  input wire tap_diff_valid_i,
  input wire tap_over_thresh_o,
  input wire [8:0] tap_threshold_o,
  input wire [AW-1:0] sens_x_i,
  input wire [AW-1:0] sens_y_i,
  input wire [AW-1:0] orient_x_o,
  input wire [4:0] orient_hyst_o,
  input wire [1:0] orient_thresh_mode_o,
  input wire [5:0] tilt_angle_i,
  input wire over_1g5_i,
  input wire slope_over_0g2_i,
  input wire slope_over_0g4_i,
  input wire orient_ud_change_i,
  input wire orient_other_change_i,
  input wire orient_blocked_o,
  input wire orient_irq_o
);
  reg [7:0] mode_r;
  reg [7:0] axis_r;
  wire [1:0] blk = mode_r[3:2];
  wire [1:0] mode = mode_r[1:0];
  wire [3:0] hyst = mode_r[7:4];
  wire rot = axis_r[7];
  wire ud_en = axis_r[6];
  wire cause = tilt_angle_i > axis_r[5:0] || over_1g5_i;
  wire blk_exp = blk != 2'h0 && (cause || (blk == 2'h2 && slope_over_0g2_i)
    || (blk == 2'h3 && slope_over_0g4_i));

  // Mirror of the orientation registers as written by the host
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= `RST_ORIENT_MODE;
      axis_r <= `RST_ORIENT_AXIS;
    end else if (reg_wr_i && reg_addr_i == `ADDR_ORIENT_MODE) begin
      mode_r <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `ADDR_ORIENT_AXIS) begin
      axis_r <= reg_wdata_i;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  lowpower_follow_a: assert property (
    $past(rst_n_i) |-> lowpower_inhibit_o == $past(tap_prefilt_sel_i))
    else $error("low-power inhibit wrong");
  tap_compare_a: assert property (
    tap_diff_valid_i ##1 $stable(tap_threshold_o) |->
    tap_over_thresh_o == ($past(tap_diff_i) >= AW'(tap_threshold_o)))
    else $error("tap compare wrong");
  axis_remap_a: assert property (
    $past(rst_n_i) |->
    orient_x_o == ($past(rot) ? $past(sens_y_i) : $past(sens_x_i)))
    else $error("axis remap wrong");
  mode_select_a: assert property (
    $past(rst_n_i) |-> orient_thresh_mode_o ==
    ($past(mode) == 2'h3 ? 2'h0 : $past(mode)))
    else $error("switching mode wrong");
  hyst_step_a: assert property (
    $past(rst_n_i) |-> orient_hyst_o == {$past(hyst), 1'b0})
    else $error("hysteresis scale wrong");
  block_mode_a: assert property (
    blk != 2'h3 |=> orient_blocked_o == $past(blk_exp))
    else $error("blocking wrong");
  block_full_a: assert property (
    blk == 2'h3 && blk_exp |=> orient_blocked_o)
    else $error("full blocking missed");
  updown_irq_a: assert property (
    orient_ud_change_i && !orient_other_change_i && blk == 2'h0 |=>
    orient_irq_o == $past(ud_en))
    else $error("up/down interrupt wrong");

  cover property (orient_irq_o);
  cover property (orient_blocked_o);
  cover property (tap_over_thresh_o);
endmodule

bind tap_orient_int_config tap_orient_checker #(.AW(AW)) chk_u (.*);

/* File: tap_orient_int_config_bench.sv */
/*
 Self-checking bench of the tap and orientation configuration block.
 Assumes the bound checker and the host model beside it.
*/
`timescale 1ns/10ps
`include "tap_orient_defines.vh"
module tap_orient_int_config_bench;
  wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  wire reg_wr_i, reg_rd_i, lowpower_inhibit_o, tap_over_thresh_o;
  wire [8:0] tap_threshold_o;
  wire tap_quiet_busy_o, tap_shock_busy_o, tap_window_busy_o;
  wire tap_quiet_done_o, tap_shock_done_o, tap_window_done_o;
  wire [15:0] orient_x_o, orient_y_o, orient_z_o;
  wire [4:0] orient_hyst_o;
  wire [1:0] orient_thresh_mode_o;
  wire [5:0] orient_theta_o;
  wire orient_blocked_o, orient_irq_o;
  reg clock_i, rst_n_i, tap_prefilt_sel_i, tap_diff_valid_i, over_1g5_i;
  reg slope_over_0g2_i, slope_over_0g4_i, orient_ud_change_i;
  reg orient_other_change_i, tap_quiet_start_i, tap_shock_start_i;
  reg tap_window_start_i;
  reg [1:0] acc_range_i;
  reg [15:0] tap_diff_i, sens_x_i, sens_y_i, sens_z_i, e;
  reg [5:0] tilt_angle_i;
  reg [2:0] orient_value_i;
  reg [7:0] d, v;
  integer i, n, fail_count, checked;
  wire [2:0] dn = {tap_window_done_o, tap_shock_done_o, tap_quiet_done_o};
  wire [2:0] bz = {tap_window_busy_o, tap_shock_busy_o, tap_quiet_busy_o};

  tap_orient_int_config #(.MS_CYCLES(10)) dut_u (.*);
  reg_host_model host_u (.clock_i(clock_i), .rdata_i(reg_rdata_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
    .rd_o(reg_rd_i));

  always #12.5 clock_i = ~clock_i;

  // Reset value and writable mask of each place
  function [15:0] tbl(input integer a);
    case (a)
      0: tbl = {`RST_TAP_TIMING, 8'hC7};
      1: tbl = {`RST_TAP_THRESH, 8'h1F};
      2: tbl = {`RST_ORIENT_MODE, 8'hFF};
      3: tbl = {`RST_ORIENT_AXIS, 8'hFF};
      default: tbl = 16'h0000;
    endcase
  endfunction
  function integer win(input [2:0] k);
    case (k)
      3'h5: win = 375;
      3'h6: win = 500;
      3'h7: win = 700;
      default: win = 50 * (k + 1);
    endcase
  endfunction
  // Threshold in half-steps of the 2g unit
  function [15:0] thr(input [4:0] f, input [1:0] r);
    thr = f == 5'h00 ? 16'h0001 << r : {11'h000, f} << (r + 1);
  endfunction

  task end_of_test;
    begin
      if (fail_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task c(input [15:0] g, input [15:0] x);
    begin
      checked = checked + 1;
      if (g !== x) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task c1(input g, input x);
    c({15'h0000, g}, {15'h0000, x});
  endtask
  task s;
    begin
      @(posedge clock_i);
      #2;
    end
  endtask
  task tmr(input integer w, input integer ms);
    begin
      {tap_window_start_i, tap_shock_start_i, tap_quiet_start_i} = 3'h1 << w;
      s;
      {tap_window_start_i, tap_shock_start_i, tap_quiet_start_i} = 3'h0;
      c1(bz[w], 1'b1);
      n = 0;
      while (dn[w] !== 1'b1 && n < 8000) begin
        s;
        n = n + 1;
      end
      c1(n >= ms * 10 - 10 && n <= ms * 10 + 2, 1'b1);
      c1(bz[w], 1'b0);
      if (n == 8000)
        end_of_test;
    end
  endtask

  initial begin
    {clock_i, rst_n_i, tap_prefilt_sel_i, tap_diff_valid_i} = 4'h0;
    {over_1g5_i, slope_over_0g2_i, slope_over_0g4_i} = 3'h0;
    {orient_ud_change_i, orient_other_change_i, acc_range_i} = 4'h0;
    {tap_quiet_start_i, tap_shock_start_i, tap_window_start_i} = 3'h0;
    {tap_diff_i, sens_x_i, sens_y_i, sens_z_i} = 64'h0;
    {tilt_angle_i, orient_value_i} = 9'h000;
    fail_count = 0;
    checked = 0;
    v = $urandom(93262);
    repeat (6) @(posedge clock_i);
    #2;
    rst_n_i = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      host_u.rd(8'h63 + i[7:0], d);
      c({8'h00, d}, tbl(i) >> 8);
      v = $urandom;
      host_u.wr(8'h63 + i[7:0], v);
      host_u.rd(8'h63 + i[7:0], d);
      c({8'h00, d}, {8'h00, v} & tbl(i));
    end
    for (i = 0; i < 8; i = i + 1) begin
      host_u.wr(`ADDR_TAP_TIMING, {i[0], i[1], 3'h0, i[2:0]});
      tmr(0, i[0] ? 20 : 30);
      tmr(1, i[1] ? 75 : 50);
      tmr(2, win(i[2:0]));
    end
    for (i = 0; i < 8; i = i + 1) begin
      v = i < 4 ? 8'h00 : $urandom;
      host_u.wr(`ADDR_TAP_THRESH, {3'h0, v[4:0]});
      acc_range_i = i[1:0];
      repeat (3) s;
      e = thr(v[4:0], i[1:0]);
      c({7'h00, tap_threshold_o}, e);
      {tap_diff_i, tap_diff_valid_i} = {e - 16'h0001, 1'b1};
      s;
      c1(tap_over_thresh_o, 1'b0);
      tap_diff_i = e;
      s;
      tap_diff_valid_i = 1'b0;
      c1(tap_over_thresh_o, 1'b1);
    end
    for (i = 1; i >= 0; i = i - 1) begin
      tap_prefilt_sel_i = i[0];
      s;
      c1(lowpower_inhibit_o, i[0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      host_u.wr(`ADDR_ORIENT_MODE, {4{i[1:0]}});
      host_u.wr(`ADDR_ORIENT_AXIS, {i[0], i[1], 6'h08});
      sens_x_i = $urandom;
      sens_y_i = $urandom;
      sens_z_i = $urandom;
      tilt_angle_i = 6'h09;
      s;
      c(orient_x_o, i[0] ? sens_y_i : sens_x_i);
      c(orient_y_o, i[0] ? sens_z_i : sens_y_i);
      c(orient_z_o, i[0] ? sens_x_i : sens_z_i);
      c({10'h000, orient_theta_o}, 16'h0008);
      c1(orient_blocked_o, i != 0);
      {tilt_angle_i, orient_ud_change_i} = 7'h01;
      s;
      orient_ud_change_i = 1'b0;
      c1(orient_irq_o, i[1]);
      slope_over_0g2_i = 1'b1;
      s;
      c1(orient_blocked_o, i == 2);
      {slope_over_0g2_i, slope_over_0g4_i} = 2'h1;
      s;
      c1(orient_blocked_o, i == 3);
      {slope_over_0g4_i, over_1g5_i} = 2'h1;
      s;
      over_1g5_i = 1'b0;
      c1(orient_blocked_o, i != 0);
      c({9'h000, orient_hyst_o, orient_thresh_mode_o}, {9'h000, i[1:0],
        i[1:0], 1'b0, i == 3 ? 2'h0 : i[1:0]});
    end
    // Mode 3 left set: a new orientation blocks for 100 ms
    orient_value_i = 3'h1;
    s;
    orient_other_change_i = 1'b1;
    s;
    c1(orient_blocked_o, 1'b1);
    c1(orient_irq_o, 1'b0);
    orient_other_change_i = 1'b0;
    n = 0;
    while (orient_blocked_o === 1'b1 && n < 1200) begin
      s;
      n = n + 1;
    end
    c1(n >= 990 && n <= 1002, 1'b1);
    orient_other_change_i = 1'b1;
    s;
    orient_other_change_i = 1'b0;
    c1(orient_irq_o, 1'b1);
    end_of_test;
  end
endmodule
